/* File: src/ltwd_pkg.sv */
// shared constants and types for the logic-test and watchdog slice
package ltwd_pkg;
  // operation selected by the opcode high nibble
  localparam logic [3:0] OPH_TSTC = 4'h6;
  localparam logic [3:0] OPH_TSTM = 4'h7;
  localparam logic [3:0] OPH_XOR = 4'hb;
  // single-byte watchdog opcodes
  localparam logic [7:0] OPC_WARM = 8'h5f;
  localparam logic [7:0] OPC_WHALT = 8'h4f;
  // addressing mode selected by the opcode low nibble
  localparam logic [3:0] MODE_RR = 4'h2;
  localparam logic [3:0] MODE_RIR = 4'h3;
  localparam logic [3:0] MODE_GG = 4'h4;
  localparam logic [3:0] MODE_GIG = 4'h5;
  localparam logic [3:0] MODE_GIM = 4'h6;
  localparam logic [3:0] MODE_IIM = 4'h7;
  // register operand prefix naming a working register
  localparam logic [3:0] WORK_PREFIX = 4'he;
  // instruction lengths in clocks
  localparam logic [3:0] CYC_SHORT = 4'h6;
  localparam logic [3:0] CYC_LONG = 4'ha;
  // watchdog terminal count, clocks
  localparam int unsigned WDT_LIMIT_DEF = 65535;
  // bus byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_INSTR = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_FLAGS = 8'h0c;
  localparam logic [7:0] OFF_RPTR = 8'h10;
  localparam logic [7:0] OFF_RFADDR = 8'h14;
  localparam logic [7:0] OFF_RFDATA = 8'h18;
  // field positions
  localparam int unsigned CTRL_GO = 0;
  localparam int unsigned CTRL_HALT = 1;
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_BAD = 1;
  localparam int unsigned STAT_ARMED = 2;
  localparam int unsigned STAT_HRUN = 3;
  // reset values
  localparam logic [7:0] RST_RPTR = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [23:0] RST_INSTR = 24'h000000;

  typedef enum logic [2:0] {
    OP_TSTC = 3'b000,
    OP_TSTM = 3'b001,
    OP_XOR = 3'b010,
    OP_WARM = 3'b011,
    OP_WHALT = 3'b100,
    OP_BAD = 3'b111
  } ltwd_op_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_ADDR = 2'b01,
    S_EXEC = 2'b10,
    S_WAIT = 2'b11
  } ltwd_state_t;

  typedef struct packed {
    logic carry;
    logic zero;
    logic sign;
    logic ovf;
    logic dec;
    logic half;
    logic [1:0] spare;
  } ltwd_flags_t;

  typedef struct packed {
    logic [7:0] b2;
    logic [7:0] b1;
    logic [7:0] opc;
  } ltwd_instr_t;
endpackage : ltwd_pkg

/* File: src/ltwd_logic_alu.sv */
// result and flag logic for masked tests and exclusive or
`timescale 1ns/1ps
module ltwd_logic_alu
  import ltwd_pkg::*;
(
  // operation and operands
  input wire ltwd_op_t op,
  input wire logic [7:0] dstVal,
  input wire logic [7:0] srcVal,
  input wire ltwd_flags_t flagsIn,
  // outcome
  output logic [7:0] result,
  output logic writeBack,
  output ltwd_flags_t flagsOut
);
  always_comb
  begin
    result = 8'h00;
    writeBack = 1'b0;
    flagsOut = flagsIn;
    case (op)
      OP_TSTC: result = ~dstVal & srcVal;
      OP_TSTM: result = dstVal & srcVal;
      OP_XOR:
      begin
        result = dstVal ^ srcVal;
        writeBack = 1'b1;
      end
      default: result = 8'h00;
    endcase
    // tests never write back, only flags move
    if (op == OP_TSTC || op == OP_TSTM || op == OP_XOR)
    begin
      flagsOut.zero = (result == 8'h00);
      flagsOut.sign = result[7];
      flagsOut.ovf = 1'b0;
    end
  end
endmodule : ltwd_logic_alu

/* File: src/ltwd_watchdog.sv */
// retriggerable watchdog counter with halt-run option
`timescale 1ns/1ps
module ltwd_watchdog
  import ltwd_pkg::*;
#(
  parameter int unsigned LIMIT = WDT_LIMIT_DEF
)
(
  // system
  input wire logic clk_sys,
  input wire logic rst,
  // strobes from the execution unit
  input wire logic armPulse,
  input wire logic haltEnPulse,
  input wire logic halted,
  // state
  output logic armed,
  output logic haltRun,
  output logic expire
);
  localparam int unsigned CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] TERM = CW'(LIMIT - 1);

  logic [CW-1:0] count_ff;
  logic [CW-1:0] nxt_count;
  logic armed_ff;
  logic nxt_armed;
  logic hrun_ff;
  logic nxt_hrun;
  logic exp_ff;
  logic nxt_exp;
  logic counting;

  assign armed = armed_ff;
  assign haltRun = hrun_ff;
  assign expire = exp_ff;

  always_comb
  begin
    // paused in halt unless halt-run was granted
    counting = armed_ff && (!halted || hrun_ff);
    nxt_armed = armed_ff;
    nxt_hrun = hrun_ff;
    nxt_count = count_ff;
    nxt_exp = 1'b0;
    if (counting)
    begin
      nxt_count = count_ff + 1'b1;
    end
    if (counting && count_ff == TERM)
    begin
      nxt_exp = 1'b1;
    end
    if (armPulse)
    begin
      nxt_armed = 1'b1;
      nxt_count = '0;
    end
    // no count clear, and ignored until armed
    if (haltEnPulse && armed_ff)
    begin
      nxt_hrun = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      count_ff <= '0;
      armed_ff <= 1'b0;
      hrun_ff <= 1'b0;
      exp_ff <= 1'b0;
    end
    else
    begin
      count_ff <= nxt_count;
      armed_ff <= nxt_armed;
      hrun_ff <= nxt_hrun;
      exp_ff <= nxt_exp;
    end
  end
endmodule : ltwd_watchdog

/* File: src/ltwd_exec_unit.sv */
// execution slice: masked tests, exclusive or, watchdog strobes
`timescale 1ns/1ps
module ltwd_exec_unit
  import ltwd_pkg::*;
#(
  parameter int unsigned WDT_LIMIT = WDT_LIMIT_DEF
)
(
  // system
  input wire logic clk_sys,
  input wire logic rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // device reset request from the watchdog
  output logic wdtReset
);
  function automatic logic [7:0] resolveReg(input logic [7:0] opnd,
                                            input logic [7:0] rp);
    // prefix e operand maps into the current working group
    resolveReg = (opnd[7:4] == WORK_PREFIX) ?
                 {rp[7:4], opnd[3:0]} : opnd;
  endfunction : resolveReg

  function automatic ltwd_op_t decodeOp(input logic [7:0] opc);
    decodeOp = OP_BAD;
    if (opc == OPC_WARM)
      decodeOp = OP_WARM;
    else if (opc == OPC_WHALT)
      decodeOp = OP_WHALT;
    else if (opc[3:0] >= MODE_RR && opc[3:0] <= MODE_IIM)
      case (opc[7:4])
        OPH_TSTC: decodeOp = OP_TSTC;
        OPH_TSTM: decodeOp = OP_TSTM;
        OPH_XOR: decodeOp = OP_XOR;
        default: decodeOp = OP_BAD;
      endcase
  endfunction : decodeOp

  logic [7:0] rfMem [256];

  ltwd_state_t state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  ltwd_instr_t instr_ff, nxt_instr;
  logic [7:0] rp_ff, nxt_rp;
  ltwd_flags_t flags_ff, nxt_flags;
  logic halt_ff, nxt_halt;
  logic bad_ff, nxt_bad;
  logic [7:0] rfAddr_ff, nxt_rfAddr;
  logic [7:0] dstAddr_ff, nxt_dstAddr;
  logic [7:0] srcAddr_ff, nxt_srcAddr;
  logic imm_ff, nxt_imm;
  logic [7:0] res_ff, nxt_res;
  logic wr_ff, nxt_wr;
  ltwd_flags_t newFlags_ff, nxt_newFlags;
  logic arm_ff, nxt_arm;
  logic hen_ff, nxt_hen;
  logic ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic wdtRst_ff;

  logic intRst, wdtExpire, wdtArmed, wdtHaltRun;
  logic busAcc, busWr, busy, commit, rfBusWr;
  ltwd_op_t opNow;
  logic [3:0] opCycles;
  logic [7:0] dstVal, srcVal, aluRes;
  logic aluWr;
  ltwd_flags_t aluFlags;

  // expiry acts like the external reset, except on the wdtRst_ff output flop
  assign intRst = rst | wdtExpire;
  assign busAcc = wb_cyc_i && wb_stb_i && !ack_ff;
  assign busWr = busAcc && wb_we_i;
  assign busy = (state_ff != S_IDLE);
  assign opNow = decodeOp(instr_ff.opc);
  assign opCycles = (instr_ff.opc[3:0] <= MODE_RIR ||
                     opNow == OP_WARM || opNow == OP_WHALT ||
                     opNow == OP_BAD) ? CYC_SHORT : CYC_LONG;
  assign commit = (state_ff == S_WAIT) && (cnt_ff == opCycles - 4'h1);
  assign dstVal = rfMem[dstAddr_ff];
  assign srcVal = imm_ff ? instr_ff.b2 : rfMem[srcAddr_ff];
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign wdtReset = wdtRst_ff;

  ltwd_logic_alu u_alu (
    .op(opNow),
    .dstVal(dstVal),
    .srcVal(srcVal),
    .flagsIn(flags_ff),
    .result(aluRes),
    .writeBack(aluWr),
    .flagsOut(aluFlags)
  );

  ltwd_watchdog #(
    .LIMIT(WDT_LIMIT)
  ) u_wdt (
    .clk_sys(clk_sys),
    .rst(intRst),
    .armPulse(arm_ff),
    .haltEnPulse(hen_ff),
    .halted(halt_ff),
    .armed(wdtArmed),
    .haltRun(wdtHaltRun),
    .expire(wdtExpire)
  );

  // operand addressing and sequencing
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_dstAddr = dstAddr_ff;
    nxt_srcAddr = srcAddr_ff;
    nxt_imm = imm_ff;
    nxt_res = res_ff;
    nxt_wr = wr_ff;
    nxt_newFlags = newFlags_ff;
    nxt_arm = 1'b0;
    nxt_hen = 1'b0;
    case (state_ff)
      S_IDLE:
      begin
        nxt_cnt = 4'h0;
        if (busWr && wb_adr_i == OFF_CTRL && wb_sel_i[0] &&
            wb_dat_i[CTRL_GO])
          nxt_state = S_ADDR;
      end
      S_ADDR:
      begin
        nxt_cnt = cnt_ff + 4'h1;
        nxt_state = S_EXEC;
        nxt_imm = 1'b0;
        case (instr_ff.opc[3:0])
          MODE_RR:
          begin
            nxt_dstAddr = {rp_ff[7:4], instr_ff.b1[7:4]};
            nxt_srcAddr = {rp_ff[7:4], instr_ff.b1[3:0]};
          end
          MODE_RIR:
          begin
            nxt_dstAddr = {rp_ff[7:4], instr_ff.b1[7:4]};
            nxt_srcAddr = rfMem[{rp_ff[7:4], instr_ff.b1[3:0]}];
          end
          MODE_GG:
          begin
            nxt_srcAddr = resolveReg(instr_ff.b1, rp_ff);
            nxt_dstAddr = resolveReg(instr_ff.b2, rp_ff);
          end
          MODE_GIG:
          begin
            nxt_srcAddr = rfMem[resolveReg(instr_ff.b1, rp_ff)];
            nxt_dstAddr = resolveReg(instr_ff.b2, rp_ff);
          end
          MODE_GIM:
          begin
            nxt_dstAddr = resolveReg(instr_ff.b1, rp_ff);
            nxt_imm = 1'b1;
          end
          MODE_IIM:
          begin
            nxt_dstAddr = rfMem[resolveReg(instr_ff.b1, rp_ff)];
            nxt_imm = 1'b1;
          end
          default: nxt_imm = 1'b0;
        endcase
      end
      S_EXEC:
      begin
        nxt_cnt = cnt_ff + 4'h1;
        nxt_state = S_WAIT;
        nxt_res = aluRes;
        nxt_wr = aluWr;
        // watchdog ops leave every flag as it was
        nxt_newFlags = aluFlags;
      end
      S_WAIT:
      begin
        nxt_cnt = cnt_ff + 4'h1;
        if (commit)
        begin
          nxt_state = S_IDLE;
          nxt_arm = (opNow == OP_WARM);
          nxt_hen = (opNow == OP_WHALT);
        end
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  // software-visible registers and bus answers
  always_comb
  begin
    nxt_instr = instr_ff;
    nxt_rp = rp_ff;
    nxt_flags = flags_ff;
    nxt_halt = halt_ff;
    nxt_bad = bad_ff;
    nxt_rfAddr = rfAddr_ff;
    nxt_ack = busAcc;
    nxt_rdat = rdat_ff;
    rfBusWr = 1'b0;
    if (busWr && wb_sel_i[0])
    begin
      case (wb_adr_i)
        OFF_CTRL: nxt_halt = wb_dat_i[CTRL_HALT];
        OFF_STATUS: nxt_bad = bad_ff & ~wb_dat_i[STAT_BAD];
        OFF_FLAGS: nxt_flags = busy ? flags_ff : wb_dat_i[7:0];
        OFF_RPTR: nxt_rp = busy ? rp_ff : wb_dat_i[7:0];
        OFF_RFADDR: nxt_rfAddr = wb_dat_i[7:0];
        OFF_RFDATA: rfBusWr = !busy;
        default: nxt_rp = rp_ff;
      endcase
    end
    // instruction bytes follow their byte lanes; frozen while busy
    if (busWr && wb_adr_i == OFF_INSTR && !busy)
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (wb_sel_i[i])
        begin
          nxt_instr[i*8 +: 8] = wb_dat_i[i*8 +: 8];
        end
      end
    end
    if (commit)
      nxt_flags = newFlags_ff;
    // a bad opcode event wins over a clear in the same cycle
    if (commit && opNow == OP_BAD)
      nxt_bad = 1'b1;
    if (busAcc && !wb_we_i)
    begin
      case (wb_adr_i)
        OFF_CTRL: nxt_rdat = {30'h0, halt_ff, busy};
        OFF_INSTR: nxt_rdat = {8'h00, instr_ff};
        OFF_STATUS: nxt_rdat = {28'h0, wdtHaltRun, wdtArmed, bad_ff, busy};
        OFF_FLAGS: nxt_rdat = {24'h0, flags_ff};
        OFF_RPTR: nxt_rdat = {24'h0, rp_ff};
        OFF_RFADDR: nxt_rdat = {24'h0, rfAddr_ff};
        OFF_RFDATA: nxt_rdat = {24'h0, rfMem[rfAddr_ff]};
        default: nxt_rdat = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (intRst)
    begin
      state_ff <= S_IDLE;
      cnt_ff <= 4'h0;
      dstAddr_ff <= 8'h00;
      srcAddr_ff <= 8'h00;
      imm_ff <= 1'b0;
      res_ff <= 8'h00;
      wr_ff <= 1'b0;
      newFlags_ff <= RST_FLAGS;
      arm_ff <= 1'b0;
      hen_ff <= 1'b0;
      instr_ff <= RST_INSTR;
      rp_ff <= RST_RPTR;
      flags_ff <= RST_FLAGS;
      halt_ff <= 1'b0;
      bad_ff <= 1'b0;
      rfAddr_ff <= 8'h00;
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      dstAddr_ff <= nxt_dstAddr;
      srcAddr_ff <= nxt_srcAddr;
      imm_ff <= nxt_imm;
      res_ff <= nxt_res;
      wr_ff <= nxt_wr;
      newFlags_ff <= nxt_newFlags;
      arm_ff <= nxt_arm;
      hen_ff <= nxt_hen;
      instr_ff <= nxt_instr;
      rp_ff <= nxt_rp;
      flags_ff <= nxt_flags;
      halt_ff <= nxt_halt;
      bad_ff <= nxt_bad;
      rfAddr_ff <= nxt_rfAddr;
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  // register file keeps its contents across resets, like real ram
  always_ff @(posedge clk_sys)
  begin
    if (commit && wr_ff)
    begin
      rfMem[dstAddr_ff] <= res_ff;
    end
    else if (rfBusWr)
    begin
      rfMem[rfAddr_ff] <= wb_dat_i[7:0];
    end
  end

  // one-cycle pulse seen outside; expiry resets every flop except this one and the register file
  always_ff @(posedge clk_sys)
  begin
    wdtRst_ff <= rst ? 1'b0 : wdtExpire;
  end
endmodule : ltwd_exec_unit

/* File: bench/ltwd_exec_checker.sv */
// port-level assertions for the execution slice
`timescale 1ns/1ps
module ltwd_exec_checker
  import ltwd_pkg::*;
#(
  parameter int unsigned WDT_LIMIT = WDT_LIMIT_DEF
)
(
  // system
  input wire logic clk_sys,
  input wire logic rst,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // watchdog
  input wire logic wdtReset
);
  logic taken;
  logic wrTaken;
  logic stRead;
  logic isLong;
  logic [7:0] goCnt_ff;
  logic [7:0] nxt_goCnt;
  logic [7:0] opc_ff;
  logic [7:0] nxt_opc;
  logic [15:0] since_ff;
  logic [15:0] nxt_since;

  assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wrTaken = taken && wb_we_i && wb_sel_i[0];
  assign stRead = taken && !wb_we_i && wb_adr_i == OFF_STATUS;
  // only x4..x7 of the three logic ops take the long count
  assign isLong = opc_ff[3:2] == 2'b01 && (opc_ff[7:4] == OPH_TSTC ||
    opc_ff[7:4] == OPH_TSTM || opc_ff[7:4] == OPH_XOR);

  always_comb
  begin
    nxt_goCnt = goCnt_ff == 8'hff ? goCnt_ff : goCnt_ff + 8'h01;
    nxt_opc = opc_ff;
    nxt_since = since_ff == 16'hffff ? since_ff : since_ff + 16'h0001;
    if (wrTaken && wb_adr_i == OFF_CTRL && wb_dat_i[0])
      nxt_goCnt = 8'h01;
    if (wrTaken && wb_adr_i == OFF_INSTR)
      nxt_opc = wb_dat_i[7:0];
    // expiry resets the block, so no operation stays in flight
    if (wdtReset)
    begin
      nxt_goCnt = 8'hff;
      nxt_opc = 8'h00;
      nxt_since = 16'h0000;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    goCnt_ff <= rst ? 8'hff : nxt_goCnt;
    opc_ff <= rst ? 8'h00 : nxt_opc;
    since_ff <= rst ? 16'h0000 : nxt_since;
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  ack_delay_a: assert property (taken |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  busy_short_a: assert property (
    stRead && !isLong && goCnt_ff inside {[2:5]} |=> wb_dat_o[0])
    else $error("short operation not busy");
  busy_long_a: assert property (
    stRead && isLong && goCnt_ff inside {[2:9]} |=> wb_dat_o[0])
    else $error("long operation not busy");
  done_short_a: assert property (
    stRead && !isLong && goCnt_ff >= 8'h08 |=> !wb_dat_o[0])
    else $error("short operation still busy");
  done_long_a: assert property (
    stRead && isLong && goCnt_ff >= 8'h0c |=> !wb_dat_o[0])
    else $error("long operation still busy");
  wdt_pulse_a: assert property (wdtReset |=> !wdtReset [*8])
    else $error("watchdog reset not a single pulse");
  wdt_gap_a: assert property (wdtReset |-> since_ff >= WDT_LIMIT)
    else $error("watchdog expired before its full count");

  long_done_c: cover property (stRead && isLong && goCnt_ff == 8'h0c);
  short_busy_c: cover property (stRead && !isLong && goCnt_ff == 8'h03);
  wdt_fire_c: cover property (wdtReset);
endmodule : ltwd_exec_checker

bind ltwd_exec_unit ltwd_exec_checker #(.WDT_LIMIT(WDT_LIMIT)) chk_i (
  .clk_sys(clk_sys),
  .rst(rst),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .wdtReset(wdtReset)
);

/* File: bench/ltwd_exec_unit_bench.sv */
// self-checking bench for the execution slice
`timescale 1ns/1ps
module ltwd_exec_unit_bench
  import ltwd_pkg::*;
;
  // short limit keeps the watchdog runs brief
  localparam int unsigned LIM = 40;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'hf;
  logic [31:0] wbDatI = 32'h0;
  logic [31:0] wbDatO;
  logic wbAck;
  logic wdtReset;
  logic [31:0] rd;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  int wdtHits = 0;
  logic [3:0] hs [3] = '{OPH_TSTC, OPH_TSTM, OPH_XOR};
  logic [15:0] vp [3] = '{16'hf28d, 16'hb5b5, 16'h0f10};
  logic [7:0] bad [3] = '{8'h61, 8'h78, 8'hb1};

  always #50 clk_sys = ~clk_sys;

  ltwd_exec_unit #(.WDT_LIMIT(LIM)) uut (
    .clk_sys(clk_sys),
    .rst(rst),
    .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb),
    .wb_we_i(wbWe),
    .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel),
    .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck),
    .wdtReset(wdtReset)
  );

  task automatic summarize;
    if (failures == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one classic cycle; entered right after a rising edge
  task automatic acc(input logic we, input logic [7:0] a,
                     input logic [31:0] d);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatI <= d;
    @(posedge clk_sys);
    while (wbAck !== 1'b1)
      @(posedge clk_sys);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk_sys);
  endtask : acc

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc

  task automatic setr(input logic [7:0] a, input logic [7:0] v);
    acc(1'b1, OFF_RFADDR, {24'h0, a});
    acc(1'b1, OFF_RFDATA, {24'h0, v});
  endtask : setr

  task automatic getr(input logic [7:0] a, input logic [7:0] e);
    acc(1'b1, OFF_RFADDR, {24'h0, a});
    acc(1'b0, OFF_RFDATA, 32'h0);
    chk({24'h0, rd[7:0]}, {24'h0, e});
  endtask : getr

  task automatic go(input logic [23:0] ins);
    int n;
    acc(1'b1, OFF_INSTR, {8'h00, ins});
    acc(1'b1, OFF_CTRL, 32'h1);
    n = 0;
    rd = 32'h1;
    while (rd[0] !== 1'b0 && n < 40)
    begin
      acc(1'b0, OFF_STATUS, 32'h0);
      n++;
    end
    chk({31'h0, rd[0]}, 32'h0);
  endtask : go

  task automatic run(input logic [7:0] opc, input logic [7:0] dv,
                     input logic [7:0] sv);
    logic [7:0] b1, b2, da, sa, r;
    case (opc[3:0])
      4'h2: {b1, b2, da, sa} = 32'h37003337;
      4'h3: {b1, b2, da, sa} = 32'h4d00347b;
      4'h4: {b1, b2, da, sa} = 32'he0d4d430;
      4'h5: {b1, b2, da, sa} = 32'h07e5351f;
      4'h6: {b1, b2, da, sa} = {8'h6c, sv, 8'h6c, 8'h50};
      default: {b1, b2, da, sa} = {8'he3, sv, 8'h3e, 8'h50};
    endcase
    case (opc[7:4])
      OPH_TSTC: r = ~dv & sv;
      OPH_TSTM: r = dv & sv;
      default: r = dv ^ sv;
    endcase
    // pointer registers first, operands may overwrite a spare one
    setr(8'h3d, 8'h7b);
    setr(8'h07, 8'h1f);
    setr(8'h33, 8'h3e);
    setr(da, dv);
    setr(sa, sv);
    acc(1'b1, OFF_FLAGS, 32'hfc);
    go({b2, b1, opc});
    rdc(OFF_FLAGS, {24'h0, 1'b1, r == 8'h0, r[7], 5'h0c});
    getr(da, opc[7:4] == OPH_XOR ? r : dv);
    getr(sa, sv);
  endtask : run

  always @(posedge clk_sys)
  begin
    cycles++;
    if (wdtReset === 1'b1)
      wdtHits++;
    if (cycles == 20000)
    begin
      failures++;
      summarize();
    end
  end

  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rdc(OFF_STATUS, 32'h0);
    rdc(8'h1c, 32'h0);
    acc(1'b1, OFF_RPTR, 32'h30);
    for (int v = 0; v < 3; v++)
      for (int h = 0; h < 3; h++)
        for (int m = 2; m < 8; m++)
          run({hs[h], m[3:0]}, vp[v][15:8], vp[v][7:0]);
    for (int i = 0; i < 3; i++)
    begin
      go({16'h0, bad[i]});
      rdc(OFF_STATUS, 32'h2);
      acc(1'b1, OFF_STATUS, 32'h2);
    end
    go(24'h00004f);
    rdc(OFF_STATUS, 32'h0);
    acc(1'b1, OFF_FLAGS, 32'hfc);
    go(24'h00005f);
    rdc(OFF_FLAGS, 32'hfc);
    rdc(OFF_STATUS, 32'h4);
    acc(1'b1, OFF_CTRL, 32'h2);
    rdc(OFF_CTRL, 32'h2);
    repeat (3 * LIM) @(posedge clk_sys);
    chk(wdtHits, 32'h0);
    acc(1'b1, OFF_CTRL, 32'h0);
    repeat (2 * LIM) @(posedge clk_sys);
    chk(wdtHits, 32'h1);
    rdc(OFF_RPTR, 32'h0);
    for (int i = 0; i < 6; i++)
      go(24'h00005f);
    chk(wdtHits, 32'h1);
    go(24'h00004f);
    rdc(OFF_STATUS, 32'hc);
    acc(1'b1, OFF_CTRL, 32'h2);
    repeat (2 * LIM) @(posedge clk_sys);
    chk(wdtHits, 32'h2);
    summarize();
  end
endmodule : ltwd_exec_unit_bench
